// File: design/tmr_pkg.sv
// Constants shared by the timer channel flag and compare output logic.
// Assumes a 32-bit APB register bus; offsets are byte addresses.
package tmr_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_ENABLES = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_OUTSEL = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0c;
    localparam logic [7:0] OFS_SLOT1 = 8'h10;
    localparam logic [7:0] OFS_SLOT2 = 8'h14;
    localparam logic [7:0] OFS_CTRL = 8'h18;

    // ------------------------------------------------------------
    // Field positions and fixed bits
    // ------------------------------------------------------------
    localparam int BIT_SLOT1 = 0;
    localparam int BIT_SLOT2 = 1;
    localparam int BIT_WRAP = 2;
    localparam int BIT_PHASE = 4;
    localparam logic [4:0] FLAG_PAD = 5'h1f;
    localparam logic [3:0] OUTSEL_PAD = 4'hf;

    // ------------------------------------------------------------
    // Reset values and counter limits
    // ------------------------------------------------------------
    localparam logic [2:0] ENABLES_RST = 3'h0;
    localparam logic [2:0] FLAGS_RST = 3'h0;
    localparam logic [3:0] OUTSEL_RST = 4'h0;
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] SLOT_RST = 16'hffff;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam logic [15:0] COUNT_MIN = 16'h0000;

    // ------------------------------------------------------------
    // Compare output selection codes and the capture edge select off code
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_LOW = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam logic [1:0] EDGE_NONE = 2'h0;
endpackage : tmr_pkg

// File: design/slot_if.sv
// Link between the flag logic and one compare output slot.
// Assumes both ends share the system clock.
interface slot_if;
    logic match;
    logic [1:0] sel;
    logic [1:0] edge_sel;
    logic pin;
    logic pin_oe;
    modport ctl (output match, output sel, output edge_sel, input pin, input pin_oe);
    modport drv (input match, input sel, input edge_sel, output pin, output pin_oe);
endinterface : slot_if

// File: design/slot_out.sv
// Compare output driver for one general slot.
// Assumes match is a one-cycle pulse on clk from the flag logic.
module slot_out (
    input wire logic clk,
    input wire logic reset,
    slot_if.drv sl
);
    logic pin_r;
    logic compare_mode;

    // A slot in capture mode never drives its pin
    assign compare_mode = (sl.edge_sel == tmr_pkg::EDGE_NONE);

    // ------------------------------------------------------------
    // Output level
    // ------------------------------------------------------------
    // Code 11 falls into default so the pin simply keeps its level
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_r <= 1'b0;
        end else if (sl.match && compare_mode) begin
            case (sl.sel)
                tmr_pkg::SEL_LOW: pin_r <= 1'b0;
                tmr_pkg::SEL_HIGH: pin_r <= 1'b1;
                default: pin_r <= pin_r;
            endcase
        end
    end

    assign sl.pin = pin_r;
    assign sl.pin_oe = compare_mode && (sl.sel == tmr_pkg::SEL_LOW || sl.sel == tmr_pkg::SEL_HIGH);

    sequence low_match_s;
        sl.match && compare_mode && sl.sel == tmr_pkg::SEL_LOW;
    endsequence

    drive_low_a: assert property (@(posedge clk) disable iff (reset) low_match_s |=> !sl.pin)
        else $error("compare output not driven low");
    capture_silent_a: assert property (@(posedge clk) disable iff (reset)
        sl.edge_sel != tmr_pkg::EDGE_NONE |-> !sl.pin_oe)
        else $error("output enabled in capture mode");
    code_hold_a: assert property (@(posedge clk) disable iff (reset)
        sl.match && sl.sel == 2'h3 |=> $stable(sl.pin) && !sl.pin_oe)
        else $error("code 11 changed the pin");
endmodule : slot_out

// File: design/timer_flags.sv
// Flag, interrupt and compare output enable logic for one timer channel.
// Assumes an APB master on clk and same-clock count, capture and transfer pulses.
//
// Implementation choices: the address map and the APB interface to the registers.
module timer_flags #(
    parameter bit PHASE_CAPABLE = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic count_tick,
    input wire logic count_down,
    input wire logic capture_one,
    input wire logic capture_two,
    input wire logic xfer_start_one,
    input wire logic xfer_start_two,
    output logic slot_one_request,
    output logic slot_two_request,
    output logic wrap_request,
    output logic irq,
    output logic compare_pin_one,
    output logic compare_pin_one_oe,
    output logic compare_pin_two,
    output logic compare_pin_two_oe
);
    logic [2:0] event_irq_enables_r;
    logic [2:0] event_flags_r;
    logic [2:0] arm_r;
    logic [3:0] compare_output_select_r;
    logic [4:0] ctrl_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [15:0] general_slot_one_r;
    logic [15:0] general_slot_two_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;
    logic setup;
    logic access;
    logic wr;
    logic mapped;
    logic going_down;
    logic wrap_evt;
    logic [1:0] match_v;
    logic [2:0] set_v;
    logic [2:0] clr_v;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero wait states; read data is latched in setup so it leaves a flop
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = prdata_r;

    // Address map and read multiplexer
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        case (paddr)
            tmr_pkg::OFS_ENABLES: rd_mux = {24'h0, tmr_pkg::FLAG_PAD, event_irq_enables_r};
            tmr_pkg::OFS_FLAGS: rd_mux = {24'h0, tmr_pkg::FLAG_PAD, event_flags_r};
            tmr_pkg::OFS_OUTSEL: rd_mux = {24'h0, tmr_pkg::OUTSEL_PAD, compare_output_select_r};
            tmr_pkg::OFS_COUNT: rd_mux = {16'h0, count_r};
            tmr_pkg::OFS_SLOT1: rd_mux = {16'h0, general_slot_one_r};
            tmr_pkg::OFS_SLOT2: rd_mux = {16'h0, general_slot_two_r};
            tmr_pkg::OFS_CTRL: rd_mux = {27'h0, ctrl_r};
            default: mapped = 1'b0;
        endcase
    end

    // Read data register
    always_ff @(posedge clk) begin
        if (reset) begin
            prdata_r <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Padding bits are never stored, so writes cannot reach them
    always_ff @(posedge clk) begin
        if (reset) begin
            event_irq_enables_r <= tmr_pkg::ENABLES_RST;
            compare_output_select_r <= tmr_pkg::OUTSEL_RST;
            ctrl_r <= tmr_pkg::CTRL_RST;
        end else if (wr) begin
            if (paddr == tmr_pkg::OFS_ENABLES) begin
                event_irq_enables_r <= pwdata[2:0];
            end
            if (paddr == tmr_pkg::OFS_OUTSEL) begin
                compare_output_select_r <= pwdata[3:0];
            end
            if (paddr == tmr_pkg::OFS_CTRL) begin
                ctrl_r <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    // Only a phase capable channel may count down
    assign going_down = PHASE_CAPABLE && ctrl_r[tmr_pkg::BIT_PHASE] && count_down;

    always_comb begin
        count_nxt = going_down ? count_r - 16'h1 : count_r + 16'h1;
    end

    // Wrap in either direction raises the same event
    assign wrap_evt = count_tick && (going_down ? count_r == tmr_pkg::COUNT_MIN
                                                : count_r == tmr_pkg::COUNT_MAX);

    // Counter update; a software write wins over a tick in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            count_r <= tmr_pkg::COUNT_RST;
        end else if (wr && paddr == tmr_pkg::OFS_COUNT) begin
            count_r <= pwdata[15:0];
        end else if (count_tick) begin
            count_r <= count_nxt;
        end
    end

    // ------------------------------------------------------------
    // General slots: compare or capture
    // ------------------------------------------------------------
    // A nonzero edge select puts the slot into capture mode
    always_ff @(posedge clk) begin
        if (reset) begin
            general_slot_one_r <= tmr_pkg::SLOT_RST;
            general_slot_two_r <= tmr_pkg::SLOT_RST;
        end else begin
            if (capture_one && ctrl_r[1:0] != tmr_pkg::EDGE_NONE) begin
                general_slot_one_r <= count_r;
            end else if (wr && paddr == tmr_pkg::OFS_SLOT1) begin
                general_slot_one_r <= pwdata[15:0];
            end
            if (capture_two && ctrl_r[3:2] != tmr_pkg::EDGE_NONE) begin
                general_slot_two_r <= count_r;
            end else if (wr && paddr == tmr_pkg::OFS_SLOT2) begin
                general_slot_two_r <= pwdata[15:0];
            end
        end
    end

    // Match fires on the tick that brings the counter onto the slot value
    assign match_v[0] = count_tick && count_nxt == general_slot_one_r && ctrl_r[1:0] == tmr_pkg::EDGE_NONE;
    assign match_v[1] = count_tick && count_nxt == general_slot_two_r && ctrl_r[3:2] == tmr_pkg::EDGE_NONE;

    // ------------------------------------------------------------
    // Event flags
    // ------------------------------------------------------------
    // Set sources per flag bit
    assign set_v[tmr_pkg::BIT_SLOT1] = match_v[0] || (capture_one && ctrl_r[1:0] != tmr_pkg::EDGE_NONE);
    assign set_v[tmr_pkg::BIT_SLOT2] = match_v[1] || (capture_two && ctrl_r[3:2] != tmr_pkg::EDGE_NONE);
    assign set_v[tmr_pkg::BIT_WRAP] = wrap_evt;

    // Clear sources: armed write of 0, or transfer controller start
    always_comb begin
        clr_v = 3'h0;
        if (wr && paddr == tmr_pkg::OFS_FLAGS) begin
            clr_v = arm_r & ~pwdata[2:0];
        end
        clr_v[tmr_pkg::BIT_SLOT1] = clr_v[tmr_pkg::BIT_SLOT1] || xfer_start_one;
        clr_v[tmr_pkg::BIT_SLOT2] = clr_v[tmr_pkg::BIT_SLOT2] || xfer_start_two;
    end

    // A new event beats a clear in the same cycle so none is lost
    always_ff @(posedge clk) begin
        if (reset) begin
            event_flags_r <= tmr_pkg::FLAGS_RST;
        end else begin
            event_flags_r <= set_v | (event_flags_r & ~clr_v);
        end
    end

    // Arming remembers which flags software last read as 1
    // Any flag write disarms, so a stale read cannot clear a later event
    always_ff @(posedge clk) begin
        if (reset) begin
            arm_r <= tmr_pkg::FLAGS_RST;
        end else if (access && paddr == tmr_pkg::OFS_FLAGS) begin
            arm_r <= pwrite ? 3'h0 : prdata_r[2:0] & event_flags_r;
        end else begin
            arm_r <= arm_r & event_flags_r & ~clr_v;
        end
    end

    // ------------------------------------------------------------
    // Requests and interrupt
    // ------------------------------------------------------------
    // Gated slot requests also start the transfer controller
    assign slot_one_request = event_flags_r[tmr_pkg::BIT_SLOT1] && event_irq_enables_r[tmr_pkg::BIT_SLOT1];
    assign slot_two_request = event_flags_r[tmr_pkg::BIT_SLOT2] && event_irq_enables_r[tmr_pkg::BIT_SLOT2];
    assign wrap_request = event_flags_r[tmr_pkg::BIT_WRAP] && event_irq_enables_r[tmr_pkg::BIT_WRAP];
    assign irq = slot_one_request || slot_two_request || wrap_request;

    // ------------------------------------------------------------
    // Compare output slots
    // ------------------------------------------------------------
    slot_if sl [2] ();
    logic [1:0] pin_v;
    logic [1:0] oe_v;

    // Slot 0 is general slot one, slot 1 is general slot two
    generate
        for (genvar i = 0; i < 2; i++) begin : g_slot
            assign sl[i].match = match_v[i];
            assign sl[i].sel = compare_output_select_r[2*i+:2];
            assign sl[i].edge_sel = ctrl_r[2*i+:2];
            assign pin_v[i] = sl[i].pin;
            assign oe_v[i] = sl[i].pin_oe;
            slot_out u_out (
                .clk(clk),
                .reset(reset),
                .sl(sl[i])
            );
        end
    endgenerate

    assign compare_pin_one = pin_v[0];
    assign compare_pin_one_oe = oe_v[0];
    assign compare_pin_two = pin_v[1];
    assign compare_pin_two_oe = oe_v[1];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Bus condition reused by several checks, and the counter condition of the upward wrap check
    sequence flags_write_s;
        wr && paddr == tmr_pkg::OFS_FLAGS;
    endsequence

    sequence up_wrap_s;
        count_tick && !going_down && count_r == tmr_pkg::COUNT_MAX && !(wr && paddr == tmr_pkg::OFS_COUNT);
    endsequence

    irq_level_a: assert property (@(posedge clk) disable iff (reset)
        irq == |(event_flags_r & event_irq_enables_r))
        else $error("interrupt level does not follow flags and enables");

    slot_one_gate_a: assert property (@(posedge clk) disable iff (reset)
        !event_irq_enables_r[0] |-> !slot_one_request)
        else $error("slot one request while disabled");

    wrap_gate_a: assert property (@(posedge clk) disable iff (reset)
        !event_irq_enables_r[2] |-> !wrap_request)
        else $error("wrap request while disabled");

    wrap_up_a: assert property (@(posedge clk) disable iff (reset)
        up_wrap_s |=> event_flags_r[2] && count_r == tmr_pkg::COUNT_MIN)
        else $error("upward wrap did not set flag");

    wrap_down_a: assert property (@(posedge clk) disable iff (reset)
        count_tick && going_down && count_r == tmr_pkg::COUNT_MIN && !wr |=> event_flags_r[2])
        else $error("downward wrap did not set flag");

    slot_two_set_a: assert property (@(posedge clk) disable iff (reset)
        capture_two && ctrl_r[3:2] != 2'h0 |=> event_flags_r[1] && general_slot_two_r == $past(count_r))
        else $error("slot two capture did not set flag");

    slot_one_set_a: assert property (@(posedge clk) disable iff (reset)
        match_v[0] |=> event_flags_r[0])
        else $error("slot one match did not set flag");

    xfer_clear_a: assert property (@(posedge clk) disable iff (reset)
        xfer_start_one && !set_v[0] |=> !event_flags_r[0])
        else $error("transfer start did not clear flag");

    unarmed_keep_a: assert property (@(posedge clk) disable iff (reset)
        flags_write_s ##0 (event_flags_r[2] && !arm_r[2]) |=> event_flags_r[2])
        else $error("unarmed clear took effect");

    pad_ones_a: assert property (@(posedge clk) disable iff (reset)
        setup && !pwrite && paddr == tmr_pkg::OFS_OUTSEL |=> prdata[7:4] == 4'hf)
        else $error("reserved bits not read as one");

    // Enables must also let requests through, and flags clear only as allowed
    slot_one_pass_a: assert property (@(posedge clk) disable iff (reset)
        event_flags_r[0] && event_irq_enables_r[0] |-> slot_one_request && irq)
        else $error("slot one request blocked while enabled");

    wrap_pass_a: assert property (@(posedge clk) disable iff (reset)
        event_flags_r[2] && event_irq_enables_r[2] |-> wrap_request && irq)
        else $error("wrap request blocked while enabled");

    slot_two_match_a: assert property (@(posedge clk) disable iff (reset)
        match_v[1] |=> event_flags_r[1])
        else $error("slot two match did not set flag");

    slot_one_capture_a: assert property (@(posedge clk) disable iff (reset)
        capture_one && ctrl_r[1:0] != tmr_pkg::EDGE_NONE |=> event_flags_r[0] && general_slot_one_r == $past(count_r))
        else $error("slot one capture did not set flag");

    xfer_two_clear_a: assert property (@(posedge clk) disable iff (reset)
        xfer_start_two && !set_v[1] |=> !event_flags_r[1])
        else $error("transfer start did not clear slot two flag");

    armed_clear_a: assert property (@(posedge clk) disable iff (reset)
        flags_write_s ##0 (arm_r[2] && !pwdata[2] && !set_v[2]) |=> !event_flags_r[2])
        else $error("armed write of 0 did not clear flag");

    write_one_a: assert property (@(posedge clk) disable iff (reset)
        flags_write_s ##0 (!event_flags_r[1] && !set_v[1]) |=> !event_flags_r[1])
        else $error("flag write set a flag");

    flag_disarm_a: assert property (@(posedge clk) disable iff (reset)
        flags_write_s |=> arm_r == 3'h0)
        else $error("flag write left bits armed");

    flag_pad_a: assert property (@(posedge clk) disable iff (reset)
        setup && !pwrite && paddr == tmr_pkg::OFS_FLAGS |=> prdata[7:3] == tmr_pkg::FLAG_PAD)
        else $error("flag padding not read as one");
endmodule : timer_flags

// File: test/xfer_model.sv
// Behavioural transfer controller that answers slot interrupt requests.
// Assumes requests are levels on clk; delay sets how many cycles it waits.
module xfer_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic [3:0] delay,
    input wire logic req_one,
    input wire logic req_two,
    output logic start_one,
    output logic start_two
);
    logic [1:0] req;
    logic [1:0] start_r;
    logic [3:0] wait_r [2];

    assign req = {req_two, req_one};
    assign start_one = start_r[0];
    assign start_two = start_r[1];

    // One start pulse per request; skip the cycle after a pulse while the flag clears
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (reset) begin
                start_r[i] <= 1'b0;
                wait_r[i] <= 4'h0;
            end else begin
                start_r[i] <= 1'b0;
                if (enable && req[i] && !start_r[i]) begin
                    if (wait_r[i] == delay) begin
                        start_r[i] <= 1'b1;
                        wait_r[i] <= 4'h0;
                    end else begin
                        wait_r[i] <= wait_r[i] + 4'h1;
                    end
                end else begin
                    wait_r[i] <= 4'h0;
                end
            end
        end
    end
endmodule : xfer_model

// File: test/tb_timer_flag_and_output_enable.sv
// Self-checking bench for the timer channel flag and compare output logic.
// Assumes a zero-wait APB slave and the transfer controller model beside it.
module tb_timer_flag_and_output_enable;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic count_tick = 1'b0;
    logic count_down = 1'b0;
    logic capture_one = 1'b0;
    logic capture_two = 1'b0;
    logic xfer_start_one;
    logic xfer_start_two;
    logic slot_one_request;
    logic slot_two_request;
    logic wrap_request;
    logic irq;
    logic compare_pin_one;
    logic compare_pin_one_oe;
    logic compare_pin_two;
    logic compare_pin_two_oe;
    logic model_on = 1'b0;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #20 clk = ~clk;

    timer_flags dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_tick(count_tick), .count_down(count_down), .capture_one(capture_one),
        .capture_two(capture_two), .xfer_start_one(xfer_start_one), .xfer_start_two(xfer_start_two),
        .slot_one_request(slot_one_request), .slot_two_request(slot_two_request),
        .wrap_request(wrap_request), .irq(irq), .compare_pin_one(compare_pin_one),
        .compare_pin_one_oe(compare_pin_one_oe), .compare_pin_two(compare_pin_two),
        .compare_pin_two_oe(compare_pin_two_oe));

    xfer_model partner (.clk(clk), .reset(reset), .enable(model_on), .delay(4'h3),
        .req_one(slot_one_request), .req_two(slot_two_request),
        .start_one(xfer_start_one), .start_two(xfer_start_two));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task end_sim;
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            end_sim();
        end
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Setup then access; hold everything until pready is sampled high
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb

    // One-cycle event pulses: bit 0 tick, bit 1 capture one, bit 2 capture two
    task pulse(input logic [2:0] which);
        @(posedge clk);
        count_tick <= which[0];
        capture_one <= which[1];
        capture_two <= which[2];
        @(posedge clk);
        count_tick <= 1'b0;
        capture_one <= 1'b0;
        capture_two <= 1'b0;
        #1;
    endtask : pulse

    // Clearing needs the read first, otherwise the write of 0 is ignored
    task clr;
        apb(1'b0, tmr_pkg::OFS_FLAGS, 32'h0);
        apb(1'b1, tmr_pkg::OFS_FLAGS, 32'h0);
    endtask : clr

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        apb(1'b0, tmr_pkg::OFS_ENABLES, 32'h0);
        chk("enables", 32'h0000_00f8, rd);
        apb(1'b0, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("flags", 32'h0000_00f8, rd);
        apb(1'b0, tmr_pkg::OFS_OUTSEL, 32'h0);
        chk("outsel", 32'h0000_00f0, rd);
        apb(1'b1, tmr_pkg::OFS_FLAGS, 32'h0000_00ff);
        apb(1'b0, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("flags after ones", 32'h0000_00f8, rd);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
    endtask : t_reset

    task t_wrap;
        apb(1'b1, tmr_pkg::OFS_COUNT, 32'h0000_ffff);
        pulse(3'h1);
        chk("wrap masked", 32'h0, 32'(wrap_request));
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, tmr_pkg::OFS_ENABLES, 32'h4);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("unarmed clear", 32'h1, 32'(wrap_request));
        apb(1'b0, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("flags wrap", 32'h0000_00fc, rd);
        apb(1'b1, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("armed clear", 32'h0, 32'(irq));
        @(posedge clk);
        count_down <= 1'b1;
        apb(1'b1, tmr_pkg::OFS_CTRL, 32'h10);
        apb(1'b1, tmr_pkg::OFS_COUNT, 32'h0);
        pulse(3'h1);
        chk("down wrap", 32'h1, 32'(irq));
        @(posedge clk);
        count_down <= 1'b0;
        clr();
        apb(1'b1, tmr_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tmr_pkg::OFS_ENABLES, 32'h0);
    endtask : t_wrap

    // Slot two takes drive 1, undefined, drive 0, off; slot one the reverse, so swapped fields show
    task t_compare;
        logic [1:0] codes [4];
        logic [1:0] pins [4];
        logic [1:0] oes [4];
        codes = '{2'h2, 2'h3, 2'h1, 2'h0};
        pins = '{2'h2, 2'h2, 2'h0, 2'h1};
        oes = '{2'h2, 2'h1, 2'h2, 2'h1};
        apb(1'b1, tmr_pkg::OFS_SLOT1, 32'h10);
        apb(1'b1, tmr_pkg::OFS_SLOT2, 32'h10);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, tmr_pkg::OFS_OUTSEL, {28'h0, codes[i], codes[3-i]});
            apb(1'b1, tmr_pkg::OFS_COUNT, 32'h0000_000f);
            pulse(3'h1);
            chk("pins", 32'(pins[i]), 32'({compare_pin_two, compare_pin_one}));
            chk("oes", 32'(oes[i]), 32'({compare_pin_two_oe, compare_pin_one_oe}));
            chk("requests off", 32'h0, 32'({slot_two_request, slot_one_request}));
            apb(1'b1, tmr_pkg::OFS_ENABLES, 32'h3);
            chk("requests", 32'h3, 32'({slot_two_request, slot_one_request}));
            clr();
            apb(1'b1, tmr_pkg::OFS_ENABLES, 32'h0);
        end
    endtask : t_compare

    task t_capture;
        apb(1'b1, tmr_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, tmr_pkg::OFS_OUTSEL, 32'h5);
        chk("capture oes", 32'h0, 32'({compare_pin_two_oe, compare_pin_one_oe}));
        apb(1'b1, tmr_pkg::OFS_COUNT, 32'h0000_1234);
        pulse(3'h6);
        apb(1'b0, tmr_pkg::OFS_SLOT1, 32'h0);
        chk("slot one", 32'h0000_1234, rd);
        apb(1'b0, tmr_pkg::OFS_SLOT2, 32'h0);
        chk("slot two", 32'h0000_1234, rd);
        apb(1'b0, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("capture flags", 32'h0000_00fb, rd);
        apb(1'b1, tmr_pkg::OFS_FLAGS, 32'h0);
        apb(1'b1, tmr_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tmr_pkg::OFS_OUTSEL, 32'h0);
    endtask : t_capture

    // Controller answers slowly; the flags must drop on their own
    task t_xfer;
        @(posedge clk);
        model_on <= 1'b1;
        apb(1'b1, tmr_pkg::OFS_ENABLES, 32'h3);
        apb(1'b1, tmr_pkg::OFS_SLOT1, 32'h20);
        apb(1'b1, tmr_pkg::OFS_SLOT2, 32'h20);
        apb(1'b1, tmr_pkg::OFS_COUNT, 32'h1f);
        pulse(3'h1);
        for (int n = 0; n < 20 && irq !== 1'b0; n++) begin
            @(posedge clk);
            #1;
        end
        chk("irq after transfer", 32'h0, 32'(irq));
        apb(1'b0, tmr_pkg::OFS_FLAGS, 32'h0);
        chk("flags after transfer", 32'h0000_00f8, rd);
        @(posedge clk);
        model_on <= 1'b0;
    endtask : t_xfer

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_wrap();
        t_compare();
        t_capture();
        t_xfer();
        end_sim();
    end
endmodule : tb_timer_flag_and_output_enable
